/* design/rhtc_pkg.sv */
// Package: constants and carrier types of the humidity sensor command slave
package rhtc_pkg;
  localparam logic [6:0] SLAVE_ADDR = 7'h40;
  localparam logic [7:0] CMD_RH_HOLD = 8'he5;
  localparam logic [7:0] CMD_RH_NOHOLD = 8'hf5;
  localparam logic [7:0] CMD_T_HOLD = 8'he3;
  localparam logic [7:0] CMD_T_NOHOLD = 8'hf3;
  localparam logic [7:0] CMD_T_PREV = 8'he0;
  localparam logic [7:0] CMD_USER_WR = 8'he6;
  localparam logic [7:0] CMD_USER_RD = 8'he7;
  localparam logic [7:0] CMD_HEAT_WR = 8'h51;
  localparam logic [7:0] CMD_HEAT_RD = 8'h11;
  localparam logic [7:0] CMD_EID1_A = 8'hfa;
  localparam logic [7:0] CMD_EID1_B = 8'h0f;
  localparam logic [7:0] CMD_EID2_A = 8'hfc;
  localparam logic [7:0] CMD_EID2_B = 8'hc9;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [7:0] CRC_POLY = 8'h31;
  localparam logic [1:0] RH_LSB_TAG = 2'b10;
  localparam logic [1:0] T_LSB_TAG = 2'b00;
  localparam logic [7:0] USER_RST = 8'h3a;
  localparam logic [7:0] HEAT_RST = 8'h00;
  localparam int CONV_TIME_US = 20;
  localparam int CLK_MHZ = 50;
  localparam int CONV_CYCLES = CONV_TIME_US * CLK_MHZ;
  localparam logic [2:0] BYTE_IDX_RST = 3'h0;
  localparam logic [2:0] BIT_IDX_RST = 3'h7;
  typedef enum logic [2:0] {
    RHTC_KIND_NONE, RHTC_KIND_RH, RHTC_KIND_T, RHTC_KIND_TPREV,
    RHTC_KIND_USER, RHTC_KIND_HEAT, RHTC_KIND_EID1, RHTC_KIND_EID2
  } rhtc_kind_t;
  typedef struct packed {
    logic [15:0] rh_word;
    logic [15:0] t_word;
  } rhtc_conv_t;
endpackage

/* design/rhtc_slave.sv */
// Module: I2C command slave of the humidity and temperature sensor
`timescale 1ns/1ps
// How it works
// - Answer as I2C slave at address 0x40
// - 0xE5/0xF5 start humidity, stretch or NACK
// - 0xE3/0xF3 start temperature, stretch or NACK
// - 0xE0 returns stored temperature
// - 0xE6 writes, 0xE7 reads user register
// - 0x51 writes, 0x11 reads heater register
// - 0xFA0F and 0xFC C9 read identifier halves
// - Hold mode stretches SCL until result ready
// - No-hold mode NACKs read address while busy
// - Checksum only after host ACKs LSB
// - CRC-8 poly 0x31, init 0x00
// - Identifier and new humidity/temperature results have CRC; register reads none
// - Stored-temperature read never sends checksum
// - Humidity conversion also stores a temperature
// - 0xE0 starts nothing; temperature commands convert afresh
// - Humidity word low bits are 10
// - Temperature word low bits are 00
// - STOP accepted before read-phase START
module rhtc_slave #(
  parameter int CONV_CYCLES = rhtc_pkg::CONV_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe_o,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [15:0] humidity_raw_word_i,
  input wire logic [15:0] temp_raw_word_i,
  input wire logic [63:0] eid_i,
  output logic [7:0] user_cfg_o,
  output logic [3:0] heater_o,
  output logic busy_o
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] crc_byte(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ rhtc_pkg::CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] scl_s_q, sda_s_q;
  logic scl_f_q, sda_f_q;
  logic [2:0] scl_s_d, sda_s_d;
  logic scl_f_d, sda_f_d;
  always_comb begin
    scl_s_d = {scl_s_q[1:0], scl_i};
    sda_s_d = {sda_s_q[1:0], sda_i};
    scl_f_d = (scl_s_q[2] == scl_s_q[1]) ? scl_s_q[1] : scl_f_q;
    sda_f_d = (sda_s_q[2] == sda_s_q[1]) ? sda_s_q[1] : sda_f_q;
  end
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
    end else begin
      scl_s_q <= scl_s_d;
      sda_s_q <= sda_s_d;
      scl_f_q <= scl_f_d;
      sda_f_q <= sda_f_d;
    end
  end
  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl_f_d & ~scl_f_q;
  assign scl_fall = ~scl_f_d & scl_f_q;
  assign start_c = scl_f_q & scl_f_d & sda_f_q & ~sda_f_d;
  assign stop_c = scl_f_q & scl_f_d & ~sda_f_q & sda_f_d;

  // ----------------------------------------
  // Protocol engine
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_BEGIN, ST_ADDR, ST_ACK, ST_WBYTE, ST_RBYTE, ST_RACK, ST_STRETCH
  } rhtc_st_t;
  rhtc_st_t st_q, st_d;
  logic [7:0] sh_q, sh_d;
  logic [2:0] bit_q, bit_d;
  logic rw_q, rw_d;
  logic ack_q, ack_d;
  logic [2:0] wcnt_q, wcnt_d;
  logic [7:0] cmd0_q, cmd0_d;
  rhtc_pkg::rhtc_kind_t kind_q, kind_d;
  logic hold_q, hold_d;
  logic [2:0] rcnt_q, rcnt_d;
  logic [7:0] crc_q, crc_d;
  logic [7:0] user_q, user_d;
  logic [3:0] heat_q, heat_d;
  logic sda_lo_q, sda_lo_d;
  logic scl_lo_q, scl_lo_d;
  rhtc_pkg::rhtc_conv_t res_q, res_d;
  logic [31:0] conv_q, conv_d;
  logic conv_rh_q, conv_rh_d;
  logic start_conv;
  logic conv_busy;
  assign conv_busy = (conv_q != 32'h0);

  // Data byte offered at read index, last-byte flags
  function automatic logic [7:0] rd_byte(input rhtc_pkg::rhtc_kind_t k, input logic [2:0] n,
                                         input rhtc_pkg::rhtc_conv_t r, input logic [7:0] u,
                                         input logic [3:0] h, input logic [63:0] e,
                                         input logic [7:0] c);
    logic [7:0] v;
    v = 8'h00;
    case (k)
      rhtc_pkg::RHTC_KIND_RH: v = (n == 3'h0) ? r.rh_word[15:8] :
        (n == 3'h1) ? r.rh_word[7:0] : c;
      rhtc_pkg::RHTC_KIND_T, rhtc_pkg::RHTC_KIND_TPREV: v = (n == 3'h0) ? r.t_word[15:8] :
        (n == 3'h1) ? r.t_word[7:0] : c;
      rhtc_pkg::RHTC_KIND_USER: v = u;
      rhtc_pkg::RHTC_KIND_HEAT: v = {4'hf, h};
      rhtc_pkg::RHTC_KIND_EID1: v = n[0] ? c : e[63 - 8 * n[2:1] -: 8];
      rhtc_pkg::RHTC_KIND_EID2: v = (n == 3'h2 || n == 3'h5) ? c :
        e[31 - 8 * ((n > 3'h2) ? n - 3'h1 : n) -: 8];
      default: v = 8'hff;
    endcase
    return v;
  endfunction

  function automatic logic last_byte(input rhtc_pkg::rhtc_kind_t k, input logic [2:0] n);
    case (k)
      rhtc_pkg::RHTC_KIND_RH, rhtc_pkg::RHTC_KIND_T: last_byte = (n == 3'h2);
      rhtc_pkg::RHTC_KIND_TPREV: last_byte = (n == 3'h1);
      rhtc_pkg::RHTC_KIND_EID1: last_byte = (n == 3'h7);
      rhtc_pkg::RHTC_KIND_EID2: last_byte = (n == 3'h5);
      default: last_byte = 1'b1;
    endcase
  endfunction

  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    bit_d = bit_q;
    rw_d = rw_q;
    ack_d = ack_q;
    wcnt_d = wcnt_q;
    cmd0_d = cmd0_q;
    kind_d = kind_q;
    hold_d = hold_q;
    rcnt_d = rcnt_q;
    crc_d = crc_q;
    user_d = user_q;
    heat_d = heat_q;
    sda_lo_d = sda_lo_q;
    scl_lo_d = 1'b0;
    start_conv = 1'b0;
    if (start_c) begin
      // Repeated start or fresh start after STOP both keep the command
      st_d = ST_BEGIN;
      bit_d = rhtc_pkg::BIT_IDX_RST;
      sda_lo_d = 1'b0;
    end else if (stop_c) begin
      st_d = ST_IDLE;
      sda_lo_d = 1'b0;
    end else begin
      case (st_q)
        ST_BEGIN: begin
          // The fall that closes a START carries no bit
          if (scl_fall) begin
            st_d = ST_ADDR;
          end
        end
        ST_ADDR, ST_WBYTE: begin
          // Same sync age as the SCL edge; a late ACK release would look low
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda_f_d};
          end
          if (scl_fall) begin
            if (bit_q == 3'h0) begin
              ack_d = 1'b0;
              if (st_q == ST_ADDR) begin
                rw_d = sh_q[0];
                wcnt_d = rhtc_pkg::BYTE_IDX_RST;
                if (sh_q[7:1] == rhtc_pkg::SLAVE_ADDR) begin
                  ack_d = ~(sh_q[0] & conv_busy & ~hold_q);
                end
              end else begin
                ack_d = 1'b1;
                wcnt_d = wcnt_q + 3'h1;
                if (wcnt_q == 3'h0) begin
                  cmd0_d = sh_q;
                  kind_d = rhtc_pkg::RHTC_KIND_NONE;
                  case (sh_q)
                    rhtc_pkg::CMD_RH_HOLD, rhtc_pkg::CMD_RH_NOHOLD: begin
                      kind_d = rhtc_pkg::RHTC_KIND_RH;
                      hold_d = (sh_q == rhtc_pkg::CMD_RH_HOLD);
                      start_conv = 1'b1;
                    end
                    rhtc_pkg::CMD_T_HOLD, rhtc_pkg::CMD_T_NOHOLD: begin
                      kind_d = rhtc_pkg::RHTC_KIND_T;
                      hold_d = (sh_q == rhtc_pkg::CMD_T_HOLD);
                      start_conv = 1'b1;
                    end
                    rhtc_pkg::CMD_T_PREV: kind_d = rhtc_pkg::RHTC_KIND_TPREV;
                    rhtc_pkg::CMD_USER_RD, rhtc_pkg::CMD_USER_WR:
                      kind_d = rhtc_pkg::RHTC_KIND_USER;
                    rhtc_pkg::CMD_HEAT_RD, rhtc_pkg::CMD_HEAT_WR:
                      kind_d = rhtc_pkg::RHTC_KIND_HEAT;
                    default: kind_d = rhtc_pkg::RHTC_KIND_NONE;
                  endcase
                end else if (wcnt_q == 3'h1) begin
                  if (cmd0_q == rhtc_pkg::CMD_USER_WR) begin
                    user_d = sh_q;
                  end else if (cmd0_q == rhtc_pkg::CMD_HEAT_WR) begin
                    heat_d = sh_q[3:0];
                  end else if (cmd0_q == rhtc_pkg::CMD_EID1_A && sh_q == rhtc_pkg::CMD_EID1_B) begin
                    kind_d = rhtc_pkg::RHTC_KIND_EID1;
                  end else if (cmd0_q == rhtc_pkg::CMD_EID2_A && sh_q == rhtc_pkg::CMD_EID2_B) begin
                    kind_d = rhtc_pkg::RHTC_KIND_EID2;
                  end
                end
              end
              sda_lo_d = ack_d;
              st_d = ack_d ? ST_ACK : ST_IDLE;
            end
            bit_d = bit_q - 3'h1;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            sda_lo_d = 1'b0;
            bit_d = rhtc_pkg::BIT_IDX_RST;
            if (rw_q) begin
              rcnt_d = rhtc_pkg::BYTE_IDX_RST;
              crc_d = rhtc_pkg::CRC_INIT;
              if (conv_busy) begin
                scl_lo_d = 1'b1;
                st_d = ST_STRETCH;
              end else begin
                sh_d = rd_byte(kind_q, 3'h0, res_q, user_q, heat_q, eid_i, rhtc_pkg::CRC_INIT);
                sda_lo_d = ~sh_d[7];
                st_d = ST_RBYTE;
              end
            end else begin
              st_d = ST_WBYTE;
            end
          end
        end
        ST_STRETCH: begin
          // Only reachable in hold mode; no-hold NACKs the address instead
          if (conv_busy) begin
            scl_lo_d = 1'b1;
          end else begin
            // Data settles a cycle before SCL is let go
            scl_lo_d = 1'b1;
            sh_d = rd_byte(kind_q, 3'h0, res_q, user_q, heat_q, eid_i, rhtc_pkg::CRC_INIT);
            sda_lo_d = ~sh_d[7];
            st_d = ST_RBYTE;
          end
        end
        ST_RBYTE: begin
          if (scl_fall) begin
            // Rotate, so the byte is whole again for the checksum
            sh_d = {sh_q[6:0], sh_q[7]};
            if (bit_q == 3'h0) begin
              sda_lo_d = 1'b0;
              st_d = ST_RACK;
            end else begin
              sda_lo_d = ~sh_q[6];
            end
            bit_d = bit_q - 3'h1;
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            ack_d = ~sda_f_d;
          end
          if (scl_fall) begin
            if (ack_q && !last_byte(kind_q, rcnt_q)) begin
              crc_d = (kind_q == rhtc_pkg::RHTC_KIND_EID1 && rcnt_q[0]) ||
                      (kind_q == rhtc_pkg::RHTC_KIND_EID2 && rcnt_q == 3'h2) ?
                      rhtc_pkg::CRC_INIT : crc_byte(crc_q, sh_q);
              if (kind_q == rhtc_pkg::RHTC_KIND_EID1 && !rcnt_q[0]) begin
                crc_d = crc_byte(rhtc_pkg::CRC_INIT, sh_q);
              end
              rcnt_d = rcnt_q + 3'h1;
              sh_d = rd_byte(kind_q, rcnt_d, res_q, user_q, heat_q, eid_i, crc_d);
              sda_lo_d = ~sh_d[7];
              bit_d = rhtc_pkg::BIT_IDX_RST;
              st_d = ST_RBYTE;
            end else begin
              st_d = ST_IDLE;
            end
          end
        end
        default: st_d = ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Conversion engine
  // ----------------------------------------
  always_comb begin
    conv_d = conv_q;
    conv_rh_d = conv_rh_q;
    res_d = res_q;
    if (start_conv) begin
      conv_d = CONV_CYCLES;
      conv_rh_d = (kind_d == rhtc_pkg::RHTC_KIND_RH);
    end else if (conv_q == 32'h1) begin
      conv_d = 32'h0;
      res_d.t_word = {temp_raw_word_i[15:2], rhtc_pkg::T_LSB_TAG};
      if (conv_rh_q) begin
        res_d.rh_word = {humidity_raw_word_i[15:2], rhtc_pkg::RH_LSB_TAG};
      end
    end else if (conv_busy) begin
      conv_d = conv_q - 32'h1;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q <= ST_IDLE;
      sh_q <= 8'h00;
      bit_q <= rhtc_pkg::BIT_IDX_RST;
      rw_q <= 1'b0;
      ack_q <= 1'b0;
      wcnt_q <= rhtc_pkg::BYTE_IDX_RST;
      cmd0_q <= 8'h00;
      kind_q <= rhtc_pkg::RHTC_KIND_NONE;
      hold_q <= 1'b0;
      rcnt_q <= rhtc_pkg::BYTE_IDX_RST;
      crc_q <= rhtc_pkg::CRC_INIT;
      user_q <= rhtc_pkg::USER_RST;
      heat_q <= rhtc_pkg::HEAT_RST[3:0];
      sda_lo_q <= 1'b0;
      scl_lo_q <= 1'b0;
      res_q <= '0;
      conv_q <= 32'h0;
      conv_rh_q <= 1'b0;
    end else begin
      st_q <= st_d;
      sh_q <= sh_d;
      bit_q <= bit_d;
      rw_q <= rw_d;
      ack_q <= ack_d;
      wcnt_q <= wcnt_d;
      cmd0_q <= cmd0_d;
      kind_q <= kind_d;
      hold_q <= hold_d;
      rcnt_q <= rcnt_d;
      crc_q <= crc_d;
      user_q <= user_d;
      heat_q <= heat_d;
      sda_lo_q <= sda_lo_d;
      scl_lo_q <= scl_lo_d;
      res_q <= res_d;
      conv_q <= conv_d;
      conv_rh_q <= conv_rh_d;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = sda_lo_q;
  assign scl_o = 1'b0;
  assign scl_oe_o = scl_lo_q;
  assign user_cfg_o = user_q;
  assign heater_o = heat_q;
  assign busy_o = conv_busy;
endmodule

/* bench/rhtc_slave_properties.sv */
// Checker: bus drive and conversion timing properties of the command slave
`timescale 1ns/1ps
// ----------------------------------------
// Checker
// ----------------------------------------
module rhtc_slave_chk #(
  parameter int CONV_CYCLES = 50
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic scl_o,
  input wire logic scl_oe_o,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic [7:0] user_cfg_o,
  input wire logic [3:0] heater_o,
  input wire logic busy_o
);
  logic [15:0] run_q, run_d, st_q, st_d;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Run lengths of busy and of a stretch, too long to unroll
  always_comb begin
    run_d = busy_o ? run_q + 16'h1 : 16'h0;
    st_d = scl_oe_o ? st_q + 16'h1 : 16'h0;
  end
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      run_q <= 16'h0;
      st_q <= 16'h0;
    end else begin
      run_q <= run_d;
      st_q <= st_d;
    end
  end
  sequence s_conv_done;
    $fell(busy_o);
  endsequence
  sequence s_stretch_on;
    $rose(scl_oe_o);
  endsequence
  AST_RESET_STATE: assert property (
    $fell(sys_rst_i) |-> user_cfg_o == 8'h3a && heater_o == 4'h0 && !busy_o)
    else $error("state after reset is wrong");
  AST_SCL_OPEN_DRAIN: assert property (scl_oe_o |-> !scl_o)
    else $error("clock line driven high");
  AST_SDA_OPEN_DRAIN: assert property (sda_oe_o |-> !sda_o)
    else $error("data line driven high");
  AST_STRETCH_WHEN_BUSY: assert property (s_stretch_on |-> busy_o)
    else $error("stretch without conversion");
  AST_STRETCH_RELEASE: assert property (
    s_conv_done ##0 scl_oe_o |-> ##[1:4] !scl_oe_o)
    else $error("stretch held after conversion");
  AST_STRETCH_AFTER_BUSY: assert property (
    scl_oe_o && !busy_o |-> $past(busy_o, 4))
    else $error("stretch outlives conversion");
  AST_BUSY_LENGTH: assert property (
    s_conv_done |-> run_q >= CONV_CYCLES - 2 && run_q <= CONV_CYCLES + 2)
    else $error("conversion length wrong");
  AST_STRETCH_BOUND: assert property (st_q <= CONV_CYCLES + 8)
    else $error("stretch too long");
endmodule

bind rhtc_slave rhtc_slave_chk #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
  .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .user_cfg_o(user_cfg_o), .heater_o(heater_o),
  .busy_o(busy_o)
);

/* bench/rhtc_host_model.sv */
// Host model: open-drain I2C master, 160 ns bit time
`timescale 1ns/1ps
module rhtc_host_model (
  input wire logic clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_low_o,
  output logic sda_low_o,
  output logic stuck_o
);
  initial begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
    stuck_o = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Release SCL; a stretch may hold it, so wait, bounded
  task automatic up();
    int n;
    n = 0;
    scl_low_o = 1'b0;
    @(negedge clk_i);
    while (!scl_i && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    if (!scl_i) stuck_o = 1'b1;
  endtask
  // Data moves one cycle after SCL falls, sampled at end of high
  task automatic bit_x(input logic b, output logic r);
    wt(1);
    sda_low_o = !b;
    wt(3);
    up();
    wt(3);
    r = sda_i;
    scl_low_o = 1'b1;
  endtask
  task automatic start();
    sda_low_o = 1'b0;
    // Give the slave time to drop its ACK before SCL rises
    wt(4);
    up();
    wt(3);
    sda_low_o = 1'b1;
    wt(4);
    scl_low_o = 1'b1;
  endtask
  task automatic stop();
    wt(1);
    sda_low_o = 1'b1;
    wt(3);
    up();
    wt(3);
    sda_low_o = 1'b0;
    wt(4);
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(!ack, r);
  endtask
endmodule

/* bench/rhtc_slave_tb.sv */
// Testbench: command slave against the host model
`timescale 1ns/1ps
module rhtc_slave_tb;
  typedef struct packed {
    logic [7:0] cmd;
    logic hold;
    logic conv;
    logic ack;
    logic [15:0] h;
    logic [15:0] t;
    logic [15:0] w;
  } rhtc_row_t;
  logic clk, rst, scl_w, sda_w, h_scl, h_sda, stuck, scl_oe, sda_oe, busy;
  logic bsy_seen, st_seen, a;
  logic [15:0] hraw, traw, w;
  logic [63:0] eid;
  logic [7:0] ucfg;
  logic [3:0] heat;
  int bad_count, checks, nk;
  rhtc_row_t rows [5];
  // Pull-ups: a released line reads high
  assign scl_w = !(scl_oe | h_scl);
  assign sda_w = !(sda_oe | h_sda);
  rhtc_slave #(.CONV_CYCLES(400)) u_dut (
    .ref_clk_i(clk), .sys_rst_i(rst), .scl_i(scl_w), .sda_i(sda_w), .scl_o(),
    .scl_oe_o(scl_oe), .sda_o(), .sda_oe_o(sda_oe), .humidity_raw_word_i(hraw),
    .temp_raw_word_i(traw), .eid_i(eid), .user_cfg_o(ucfg), .heater_o(heat), .busy_o(busy)
  );
  rhtc_host_model u_host (
    .clk_i(clk), .scl_i(scl_w), .sda_i(sda_w), .scl_low_o(h_scl), .sda_low_o(h_sda),
    .stuck_o(stuck)
  );
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (busy) bsy_seen <= 1'b1;
    if (scl_oe) st_seen <= 1'b1;
  end
  always @(posedge stuck) begin
    bad_count++;
    conclude();
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] b);
    c = c ^ b;
    for (int i = 0; i < 8; i++) c = c[7] ? {c[6:0], 1'b0} ^ 8'h31 : {c[6:0], 1'b0};
    return c;
  endfunction
  task automatic wb(input logic [7:0] d, input logic e);
    u_host.wr_byte(d, a);
    chk(a, e);
  endtask
  task automatic rb(input logic ack, input logic [7:0] e);
    logic [7:0] d;
    u_host.rd_byte(ack, d);
    chk(d, e);
  endtask
  task automatic cmd(input logic [7:0] c0, input logic [7:0] c1, input logic two);
    u_host.start();
    wb(8'h80, 1'b1);
    wb(c0, 1'b1);
    if (two) wb(c1, 1'b1);
  endtask
  // Read address, retried while refused
  task automatic rd_open(input logic gap);
    nk = 0;
    if (gap) u_host.stop();
    u_host.start();
    u_host.wr_byte(8'h81, a);
    while (!a && nk < 50) begin
      nk++;
      u_host.stop();
      u_host.start();
      u_host.wr_byte(8'h81, a);
    end
    chk(a, 1'b1);
  endtask
  task automatic conclude();
    if (bad_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    hraw = 16'h0;
    traw = 16'h0;
    eid = 64'h0123456789abcdef;
    bad_count = 0;
    checks = 0;
    bsy_seen = 1'b0;
    st_seen = 1'b0;
    rows = '{'{8'he3, 1'b1, 1'b1, 1'b1, 16'h0, 16'h6787, 16'h6784},
      '{8'hf3, 1'b0, 1'b1, 1'b1, 16'h0, 16'ha5a7, 16'ha5a4},
      '{8'he5, 1'b1, 1'b1, 1'b1, 16'h8001, 16'h1111, 16'h8002},
      '{8'hf5, 1'b0, 1'b1, 1'b0, 16'h7ffd, 16'h3c3f, 16'h7ffe},
      '{8'he0, 1'b0, 1'b0, 1'b1, 16'h7ffd, 16'hffff, 16'h3c3c}};
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
    chk({ucfg, heat, busy}, {8'h3a, 4'h0, 1'b0});
    for (int i = 0; i < 5; i++) begin
      hraw = rows[i].h;
      traw = rows[i].t;
      bsy_seen = 1'b0;
      st_seen = 1'b0;
      cmd(rows[i].cmd, 8'h0, 1'b0);
      rd_open(i[0]);
      rb(1'b1, rows[i].w[15:8]);
      rb(rows[i].ack, rows[i].w[7:0]);
      w = rows[i].w;
      if (rows[i].ack) rb(1'b0, rows[i].conv ? crc(crc(8'h0, w[15:8]), w[7:0]) : 8'hff);
      u_host.stop();
      chk({bsy_seen, st_seen, nk != 0}, {rows[i].conv, rows[i].hold, !rows[i].hold & rows[i].conv});
    end
    // ----------------------------------------
    // Foreign address, registers, identifier
    // ----------------------------------------
    u_host.start();
    wb(8'h82, 1'b0);
    u_host.stop();
    cmd(8'he6, 8'h0, 1'b0);
    wb(8'h3b, 1'b1);
    u_host.stop();
    chk(ucfg, 8'h3b);
    cmd(8'h51, 8'h0, 1'b0);
    wb(8'h0a, 1'b1);
    u_host.stop();
    chk(heat, 4'ha);
    cmd(8'he7, 8'h0, 1'b0);
    rd_open(1'b0);
    rb(1'b1, 8'h3b);
    rb(1'b0, 8'hff);
    u_host.stop();
    cmd(8'h11, 8'h0, 1'b0);
    rd_open(1'b1);
    rb(1'b1, 8'hfa);
    rb(1'b0, 8'hff);
    u_host.stop();
    cmd(8'hfa, 8'h0f, 1'b1);
    rd_open(1'b0);
    for (int k = 0; k < 4; k++) begin
      w[7:0] = eid[63-8*k -: 8];
      rb(1'b1, w[7:0]);
      rb(k < 3, crc(8'h0, w[7:0]));
    end
    u_host.stop();
    cmd(8'hfc, 8'hc9, 1'b1);
    rd_open(1'b0);
    for (int k = 0; k < 2; k++) begin
      w = eid[31-16*k -: 16];
      rb(1'b1, w[15:8]);
      rb(1'b1, w[7:0]);
      rb(k == 0, crc(crc(8'h0, w[15:8]), w[7:0]));
    end
    u_host.stop();
    // Reset in mid-run restores the registers
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
    chk({ucfg, heat}, {8'h3a, 4'h0});
    conclude();
  end
endmodule
